/* rtl/bml_btn_if.sv */
// button events passed from the conditioner to the controller
`timescale 1ns/1ps
interface bml_btn_if;
  // 1 ms strobe
  logic tick;
  // debounced button level, high while pressed
  logic held;
  // release before the flash threshold
  logic brief;
  // held past the flash threshold
  logic warn;
  // one pulse on reaching the action hold time
  logic act;
  // one pulse on reaching the reset hold time
  logic wipe;
  modport src (output tick, held, brief, warn, act, wipe);
  modport dst (input tick, held, brief, warn, act, wipe);
endinterface : bml_btn_if

/* rtl/bml_button.sv */
// push button synchroniser, debouncer and hold timer
`timescale 1ns/1ps
module bml_button #(
  parameter int unsigned TICK_CYC = bml_pkg::TICK_CYC,
  parameter int unsigned FLASH_MS = bml_pkg::FLASH_HOLD_MS,
  parameter int unsigned ACT_MS = bml_pkg::ACT_HOLD_MS,
  parameter int unsigned RESET_MS = bml_pkg::RESET_HOLD_MS
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic button_n_i,
  bml_btn_if.src btn
);
  import bml_pkg::*;

  logic sync1;
  logic sync2;
  logic [TICK_W-1:0] pre;
  logic [MS_W-1:0] deb;
  logic [MS_W-1:0] hold_ms;
  logic held;
  logic held_q;
  wire pressed_raw = ~sync2;
  wire tick = (pre == TICK_W'(TICK_CYC - 1));
  wire deb_done = tick && (deb == MS_W'(DEBOUNCE_MS - 1));

  ////////////////////////////////////////////////////////////
  // pin is asynchronous to mclk
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1 <= 1'h1;
      sync2 <= 1'h1;
    end else begin
      sync1 <= button_n_i;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) pre <= '0;
    else pre <= tick ? '0 : pre + 1'h1;
  end

  ////////////////////////////////////////////////////////////
  // contact bounce shorter than the debounce time is ignored
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      deb <= '0;
      held <= 1'h0;
    end else if (pressed_raw == held) begin
      deb <= '0;
    end else if (deb_done) begin
      deb <= '0;
      held <= pressed_raw;
    end else if (tick) begin
      deb <= deb + 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  // saturates so one hold fires each action once
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_ms <= '0;
      held_q <= 1'h0;
    end else begin
      held_q <= held;
      if (!held) hold_ms <= '0;
      else if (tick && hold_ms != MS_W'(RESET_MS)) hold_ms <= hold_ms + 1'h1;
    end
  end

  assign btn.tick = tick;
  assign btn.held = held;
  assign btn.brief = held_q && !held && (hold_ms < MS_W'(FLASH_MS));
  assign btn.warn = held && (hold_ms >= MS_W'(FLASH_MS));
  assign btn.act = held && tick && (hold_ms == MS_W'(ACT_MS - 1));
  assign btn.wipe = held && tick && (hold_ms == MS_W'(RESET_MS - 1));
endmodule : bml_button

/* rtl/bml_ctrl.sv */
// front panel button and status lamp controller
`timescale 1ns/1ps
// Function
// - brief press advances mode A-B-C-D cyclically
// - one idle minute returns to mode A
// - mode lamp off, green, orange, flashing
// - mode A twelve second hold: factory reset
// - early release in A cancels reset
// - A or D five second hold captures mask
// - early release keeps previous fault mask
// - mode lamp flashes after three seconds hold, except in C
// - mode B five second hold toggles manager
// - early release in B aborts toggle
// - manager enable also enables media redundancy
// - ring lamp off, green, flashing on switch
// - standby lamp off, green, flashing when active
// - startup fault lamp red, flash bad image
// - operating error lights red, opens contact
// - deviation from captured mask is fault
module bml_ctrl #(
  parameter int unsigned TICK_CYC = bml_pkg::TICK_CYC,
  parameter int unsigned FLASH_MS = bml_pkg::FLASH_HOLD_MS,
  parameter int unsigned ACT_MS = bml_pkg::ACT_HOLD_MS,
  parameter int unsigned RESET_MS = bml_pkg::RESET_HOLD_MS,
  parameter int unsigned IDLE_MS = bml_pkg::IDLE_MS
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic button_n_i,
  input wire logic [bml_pkg::PORT_N-1:0] port_up_i,
  input wire logic [bml_pkg::PSU_N-1:0] psu_ok_i,
  input wire logic error_i,
  input wire logic startup_done_i,
  input wire logic fw_bad_i,
  input wire logic ring_switched_i,
  input wire logic standby_en_i,
  input wire logic standby_active_i,
  output bml_pkg::bml_mode_e view_mode_o,
  output logic [2:0] view_selector_lamp_o,
  output logic ring_manager_lamp_o,
  output logic standby_lamp_o,
  output logic fault_lamp_o,
  output logic contact_open_o,
  output logic factory_reset_o,
  output logic mask_capture_o,
  output logic [bml_pkg::MASK_W-1:0] fault_mask_o,
  output logic redundancy_mgr_o,
  output logic media_redundancy_o
);
  import bml_pkg::*;

  bml_btn_if btn_bus ();
  bml_mode_e mode;
  bml_mode_e next_mode;
  logic [MS_W-1:0] idle_ms;
  logic [MS_W-1:0] blink_ms;
  logic blink;

  ////////////////////////////////////////////////////////////
  // button conditioning
  bml_button #(
    .TICK_CYC(TICK_CYC),
    .FLASH_MS(FLASH_MS),
    .ACT_MS(ACT_MS),
    .RESET_MS(RESET_MS)
  ) u_button (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .button_n_i(button_n_i),
    .btn(btn_bus)
  );

  ////////////////////////////////////////////////////////////
  // shared flash phase, so every flashing lamp blinks in step
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blink_ms <= '0;
      blink <= 1'h0;
    end else if (btn_bus.tick) begin
      if (blink_ms == MS_W'(BLINK_HALF_MS - 1)) begin
        blink_ms <= '0;
        blink <= ~blink;
      end else begin
        blink_ms <= blink_ms + 1'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // inactivity timer, any press restarts it
  wire idle_hit = btn_bus.tick && !btn_bus.held && (idle_ms == MS_W'(IDLE_MS - 1));

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) idle_ms <= '0;
    else if (btn_bus.held) idle_ms <= '0;
    else if (btn_bus.tick && idle_ms != MS_W'(IDLE_MS)) idle_ms <= idle_ms + 1'h1;
  end

  ////////////////////////////////////////////////////////////
  // display mode state
  always_comb begin
    next_mode = mode;
    if (btn_bus.brief) begin
      unique case (mode)
        MODE_A: next_mode = MODE_B;
        MODE_B: next_mode = MODE_C;
        MODE_C: next_mode = MODE_D;
        MODE_D: next_mode = MODE_A;
      endcase
    end else if (idle_hit) begin
      next_mode = MODE_A;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) mode <= MODE_A;
    else mode <= next_mode;
  end

  ////////////////////////////////////////////////////////////
  // hold actions; act and wipe only fire at full hold, so early release does nothing
  // no hold action decoded for mode C
  wire in_a = (mode == MODE_A);
  wire in_b = (mode == MODE_B);
  wire in_d = (mode == MODE_D);
  // mask capture in A or D
  wire do_mask = btn_bus.act && (in_a || in_d);
  wire do_mgr = btn_bus.act && in_b;
  wire do_wipe = btn_bus.wipe && in_a;
  wire [MASK_W-1:0] live_state = {psu_ok_i, port_up_i};

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) fault_mask_o <= MASK_RST;
    else if (do_mask) fault_mask_o <= live_state;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      redundancy_mgr_o <= MGR_RST;
      media_redundancy_o <= MEDIA_RST;
    end else if (do_mgr) begin
      redundancy_mgr_o <= ~redundancy_mgr_o;
      if (!redundancy_mgr_o) media_redundancy_o <= 1'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      factory_reset_o <= 1'h0;
      mask_capture_o <= 1'h0;
    end else begin
      factory_reset_o <= do_wipe;
      mask_capture_o <= do_mask;
    end
  end

  ////////////////////////////////////////////////////////////
  // lamp selection
  // every flashing lamp shares the common blink phase
  function automatic logic lit_or_flash(input logic flash, input logic phase);
    return flash ? phase : 1'h1;
  endfunction : lit_or_flash

  // pending action flash, mode C has none
  wire pending = btn_bus.warn && (mode != MODE_C);
  wire [2:0] mode_col = in_a ? LAMP_OFF :
                        in_b ? LAMP_GREEN :
                        in_d ? (blink ? LAMP_YELLOW : LAMP_ORANGE) : LAMP_ORANGE;
  wire [2:0] pend_col = in_a ? LAMP_YELLOW : mode_col;
  wire [2:0] next_view = pending ? (blink ? pend_col : LAMP_OFF) : mode_col;
  wire deviation = (live_state != fault_mask_o);
  wire fault = deviation || error_i;
  wire start_red = lit_or_flash(fw_bad_i, blink);
  wire next_fault = startup_done_i ? fault : start_red;
  wire next_ring = redundancy_mgr_o && lit_or_flash(ring_switched_i, blink);
  wire next_standby = standby_en_i && lit_or_flash(standby_active_i, blink);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      view_selector_lamp_o <= LAMP_OFF;
      ring_manager_lamp_o <= 1'h0;
      standby_lamp_o <= 1'h0;
      fault_lamp_o <= 1'h1;
      contact_open_o <= 1'h0;
    end else begin
      view_selector_lamp_o <= next_view;
      ring_manager_lamp_o <= next_ring;
      standby_lamp_o <= next_standby;
      fault_lamp_o <= next_fault;
      contact_open_o <= startup_done_i && fault;
    end
  end

  assign view_mode_o = mode;

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  mode_advance_a: assert property (
    btn_bus.brief && in_a |=> mode == MODE_B ##0 1'h1)
    else $error("brief press in A did not reach B");

  three_to_d_a: assert property (
    btn_bus.brief && mode == MODE_C |=> mode == MODE_D)
    else $error("brief press in C did not reach D");

  idle_return_a: assert property (
    idle_hit && !btn_bus.brief |=> mode == MODE_A)
    else $error("idle timeout did not return to A");

  mode_hold_a: assert property (
    !btn_bus.brief && !idle_hit |=> $stable(mode))
    else $error("mode changed without press or timeout");

  c_lamp_a: assert property (
    mode == MODE_C ##1 mode == MODE_C |-> view_selector_lamp_o == LAMP_ORANGE)
    else $error("mode C lamp not steady orange");

  a_dark_a: assert property (
    (in_a && !btn_bus.warn) ##1 (in_a && !btn_bus.warn) |-> view_selector_lamp_o == LAMP_OFF)
    else $error("mode A lamp not off");

  b_lamp_a: assert property (
    (in_b && !btn_bus.warn) ##1 (in_b && !btn_bus.warn) |-> view_selector_lamp_o == LAMP_GREEN)
    else $error("mode B lamp not green");

  pend_flash_a: assert property (
    (in_a && btn_bus.warn && blink) ##1 in_a |-> view_selector_lamp_o == LAMP_YELLOW)
    else $error("pending flash missing in A");

  reset_cause_a: assert property (
    factory_reset_o |-> $past(btn_bus.wipe) && $past(in_a))
    else $error("factory reset without full hold in A");

  reset_fire_a: assert property (
    btn_bus.wipe && in_a |=> factory_reset_o ##1 !factory_reset_o)
    else $error("factory reset pulse wrong");

  mask_take_a: assert property (
    mask_capture_o |-> fault_mask_o == $past(live_state))
    else $error("captured mask differs from state");

  mask_keep_a: assert property (
    !$past(do_mask) |-> $stable(fault_mask_o))
    else $error("mask changed without capture");

  mgr_toggle_a: assert property (
    do_mgr |=> redundancy_mgr_o != $past(redundancy_mgr_o))
    else $error("manager role did not toggle");

  mgr_abort_a: assert property (
    !do_mgr |=> $stable(redundancy_mgr_o))
    else $error("manager role moved without hold");

  c_no_act_a: assert property (
    mode == MODE_C |=> !mask_capture_o && !factory_reset_o && $stable(redundancy_mgr_o))
    else $error("action taken in mode C");

  media_on_a: assert property (
    $rose(redundancy_mgr_o) |-> media_redundancy_o)
    else $error("media redundancy off with manager on");

  media_keep_a: assert property (
    $fell(redundancy_mgr_o) |-> media_redundancy_o)
    else $error("media redundancy dropped on disable");

  ring_off_a: assert property (
    !redundancy_mgr_o ##1 !redundancy_mgr_o |-> !ring_manager_lamp_o)
    else $error("ring lamp lit without manager role");

  standby_steady_a: assert property (
    (standby_en_i && !standby_active_i) |=> standby_lamp_o)
    else $error("standby lamp not steady green");

  boot_red_a: assert property (
    (!startup_done_i && !fw_bad_i) |=> fault_lamp_o)
    else $error("fault lamp not red during startup");

  contact_red_a: assert property (
    contact_open_o |-> fault_lamp_o)
    else $error("contact open with fault lamp dark");

  deviate_a: assert property (
    startup_done_i && deviation |=> contact_open_o && fault_lamp_o)
    else $error("mask deviation not reported");

  reset_held_a: assert property (
    !btn_bus.held |=> !factory_reset_o)
    else $error("factory reset without button held");

  mgr_held_a: assert property (
    !btn_bus.held |=> $stable(redundancy_mgr_o))
    else $error("manager role moved with button free");

  mask_held_a: assert property (
    !btn_bus.held |=> !mask_capture_o)
    else $error("mask captured with button free");

  long_no_step_a: assert property (
    btn_bus.warn ##1 !btn_bus.held |-> !btn_bus.brief)
    else $error("long hold counted as brief press");

  d_lamp_a: assert property (
    (in_d && !btn_bus.warn) ##1 (in_d && !btn_bus.warn) |-> view_selector_lamp_o inside {LAMP_YELLOW, LAMP_ORANGE})
    else $error("mode D lamp not yellow or orange");

  ring_steady_a: assert property (
    redundancy_mgr_o && !ring_switched_i |=> ring_manager_lamp_o)
    else $error("ring lamp not steady green");

  standby_off_a: assert property (
    !standby_en_i |=> !standby_lamp_o)
    else $error("standby lamp lit while disabled");

  quiet_dark_a: assert property (
    startup_done_i && !error_i && !deviation |=> !fault_lamp_o && !contact_open_o)
    else $error("fault shown without a problem");

  image_flash_a: assert property (
    !startup_done_i && fw_bad_i && !blink |=> !fault_lamp_o)
    else $error("bad image lamp not flashing");

  reach_d_c: cover property (mode == MODE_C ##1 mode == MODE_D);
  wipe_c: cover property (factory_reset_o);
  mgr_on_c: cover property ($rose(redundancy_mgr_o));
  pend_b_c: cover property (btn_bus.warn && in_b);
  idle_c: cover property (idle_hit && !in_a);
endmodule : bml_ctrl

/* rtl/bml_pkg.sv */
// shared constants and types of the button and lamp controller
package bml_pkg;
  ////////////////////////////////////////////////////////////
  // clock and time base
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TICK_W = 17;
  localparam int unsigned MS_W = 16;
  ////////////////////////////////////////////////////////////
  // times, in milliseconds of the tick, except ACT_HOLD_S, RESET_HOLD_S and IDLE_S in seconds
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned FLASH_HOLD_MS = 3000;
  localparam int unsigned ACT_HOLD_S = 5;
  localparam int unsigned ACT_HOLD_MS = ACT_HOLD_S * 1000;
  localparam int unsigned RESET_HOLD_S = 12;
  localparam int unsigned RESET_HOLD_MS = RESET_HOLD_S * 1000;
  localparam int unsigned IDLE_S = 60;
  localparam int unsigned IDLE_MS = IDLE_S * 1000;
  localparam int unsigned BLINK_HALF_MS = 250;
  ////////////////////////////////////////////////////////////
  // monitored state and fault mask
  localparam int unsigned PORT_N = 8;
  localparam int unsigned PSU_N = 2;
  localparam int unsigned MASK_W = PORT_N + PSU_N;
  localparam logic [MASK_W-1:0] MASK_RST = 10'h000;
  localparam logic MGR_RST = 1'h0;
  localparam logic MEDIA_RST = 1'h0;
  ////////////////////////////////////////////////////////////
  // lamp colour codes, bit 0 green, bit 1 orange, bit 2 yellow
  localparam logic [2:0] LAMP_OFF = 3'h0;
  localparam logic [2:0] LAMP_GREEN = 3'h1;
  localparam logic [2:0] LAMP_ORANGE = 3'h2;
  localparam logic [2:0] LAMP_YELLOW = 3'h4;

  typedef enum logic [3:0] {
    MODE_A = 4'h1,
    MODE_B = 4'h2,
    MODE_C = 4'h4,
    MODE_D = 4'h8
  } bml_mode_e;
endpackage : bml_pkg

/* tb/bml_operator.sv */
// operator model: presses and releases the front panel button
`timescale 1ns/1ps
module bml_operator #(
  parameter int unsigned TICK_CYC = 4
) (
  input wire logic mclk_i,
  output logic button_n_o
);
  // pulled up while nobody touches the button
  initial button_n_o = 1'b1;

  task automatic hold(input int unsigned ms);
    // contacts chatter before they settle
    repeat (3) begin
      @(negedge mclk_i) button_n_o = 1'b0;
      @(negedge mclk_i) button_n_o = 1'b1;
    end
    @(negedge mclk_i) button_n_o = 1'b0;
    repeat (ms * TICK_CYC) @(negedge mclk_i);
    button_n_o = 1'b1;
    // room for the release to be debounced
    repeat (60 * TICK_CYC) @(negedge mclk_i);
  endtask : hold
endmodule : bml_operator

/* tb/button_led_mode_controller_tb.sv */
// self-checking bench of the button and lamp controller
`timescale 1ns/1ps
module button_led_mode_controller_tb;
  import bml_pkg::*;
  // short times keep the run small, still flash < action < wipe
  localparam int unsigned TK = 4;
  localparam int unsigned FL = 100;
  localparam int unsigned AC = 700;
  localparam int unsigned RS = 1000;
  localparam int unsigned ID = 1500;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic button_n;
  logic [PORT_N-1:0] port_up_i = '0;
  logic [PSU_N-1:0] psu_ok_i = '0;
  logic error_i = 1'b0;
  logic startup_done_i = 1'b0;
  logic fw_bad_i = 1'b0;
  logic ring_switched_i = 1'b0;
  logic standby_en_i = 1'b0;
  logic standby_active_i = 1'b0;
  bml_mode_e view_mode_o;
  logic [2:0] view_selector_lamp_o;
  logic ring_manager_lamp_o, standby_lamp_o, fault_lamp_o, contact_open_o;
  logic factory_reset_o, mask_capture_o, redundancy_mgr_o, media_redundancy_o;
  logic [MASK_W-1:0] fault_mask_o;
  int num_errors = 0;
  int n_tests = 0;
  logic [15:0] notes[$];
  logic [7:0] seen;
  bml_mode_e prev_mode;
  logic [1:0] prev_role;

  always #4 mclk_i = ~mclk_i;

  bml_operator #(.TICK_CYC(TK)) op (.mclk_i(mclk_i), .button_n_o(button_n));

  bml_ctrl #(.TICK_CYC(TK), .FLASH_MS(FL), .ACT_MS(AC), .RESET_MS(RS), .IDLE_MS(ID)) uut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .button_n_i(button_n), .port_up_i(port_up_i),
    .psu_ok_i(psu_ok_i), .error_i(error_i), .startup_done_i(startup_done_i), .fw_bad_i(fw_bad_i),
    .ring_switched_i(ring_switched_i), .standby_en_i(standby_en_i),
    .standby_active_i(standby_active_i), .view_mode_o(view_mode_o),
    .view_selector_lamp_o(view_selector_lamp_o), .ring_manager_lamp_o(ring_manager_lamp_o),
    .standby_lamp_o(standby_lamp_o), .fault_lamp_o(fault_lamp_o), .contact_open_o(contact_open_o),
    .factory_reset_o(factory_reset_o), .mask_capture_o(mask_capture_o), .fault_mask_o(fault_mask_o),
    .redundancy_mgr_o(redundancy_mgr_o), .media_redundancy_o(media_redundancy_o));

  ////////////////////////////////////////////////////////////
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // event code: kind nibble, then the value
  task automatic take(input string what, input logic [15:0] ev);
    if (notes.size() == 0) begin
      check(what, ev, 16'hFFFF);
    end else begin
      check(what, ev, notes.pop_front());
    end
  endtask : take

  function automatic logic [2:0] pick(input int sel);
    case (sel)
      0: return view_selector_lamp_o;
      1: return {2'h0, ring_manager_lamp_o};
      2: return {2'h0, standby_lamp_o};
      default: return {2'h0, fault_lamp_o};
    endcase
  endfunction : pick

  // collects every colour a lamp shows, so flashing and steady differ
  task automatic watch(input int sel, input int unsigned ms, input logic [7:0] exp, input string what);
    seen = 8'h00;
    repeat (ms * TK) begin
      @(negedge mclk_i);
      seen[pick(sel)] = 1'b1;
    end
    check(what, {8'h00, seen}, {8'h00, exp});
  endtask : watch

  task automatic brief(input bml_mode_e m);
    notes.push_back({12'h100, m});
    op.hold(40);
  endtask : brief

  ////////////////////////////////////////////////////////////
  always @(negedge mclk_i) begin
    if (!resetn_i) begin
      prev_mode = MODE_A;
      prev_role = 2'h0;
    end else begin
      if (view_mode_o !== prev_mode) take("mode", {12'h100, view_mode_o});
      if (mask_capture_o === 1'b1) take("mask", {6'h08, fault_mask_o});
      if (factory_reset_o === 1'b1) take("wipe", 16'h3000);
      if ({media_redundancy_o, redundancy_mgr_o} !== prev_role)
        take("role", {14'h1000, media_redundancy_o, redundancy_mgr_o});
      prev_mode = view_mode_o;
      prev_role = {media_redundancy_o, redundancy_mgr_o};
    end
  end

  initial begin
    #(95000 * 8);
    num_errors++;
    final_report();
  end

  initial begin
    void'($urandom(6));
    repeat (16) @(negedge mclk_i);
    resetn_i = 1'b1;
    @(negedge mclk_i);
    check("mode", 16'(view_mode_o), 16'(MODE_A));
    check("role", {14'h0, media_redundancy_o, redundancy_mgr_o}, 16'h0);
    port_up_i = 8'($urandom) | 8'h01;
    psu_ok_i = 2'($urandom);
    fw_bad_i = 1'b1;
    watch(3, 550, 8'h03, "fault");
    fw_bad_i = 1'b0;
    watch(3, 550, 8'h02, "fault");
    startup_done_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    check("alarm", {14'h0, fault_lamp_o, contact_open_o}, 16'h3);
    // early release, wipe with capture on the way, then plain capture
    op.hold(300);
    notes.push_back({6'h08, psu_ok_i, port_up_i});
    notes.push_back(16'h3000);
    op.hold(RS + 100);
    notes.push_back({6'h08, psu_ok_i, port_up_i});
    op.hold(AC + 100);
    check("alarm", {14'h0, fault_lamp_o, contact_open_o}, 16'h0);
    error_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    check("alarm", {14'h0, fault_lamp_o, contact_open_o}, 16'h3);
    error_i = 1'b0;
    brief(MODE_B);
    watch(0, 550, 8'h02, "view");
    notes.push_back({14'h1000, 2'h3});
    fork
      op.hold(AC + 100);
      begin
        repeat ((FL + 50) * TK) @(negedge mclk_i);
        watch(0, 520, 8'h03, "pending");
      end
    join
    op.hold(300);
    watch(1, 550, 8'h02, "ring");
    ring_switched_i = 1'b1;
    watch(1, 550, 8'h03, "ring");
    ring_switched_i = 1'b0;
    notes.push_back({14'h1000, 2'h2});
    op.hold(AC + 100);
    // idle return to mode A lands while the standby lamp is watched
    notes.push_back({12'h100, MODE_A});
    watch(2, 550, 8'h01, "standby");
    standby_en_i = 1'b1;
    watch(2, 550, 8'h02, "standby");
    standby_active_i = 1'b1;
    watch(2, 550, 8'h03, "standby");
    repeat (200 * TK) @(negedge mclk_i);
    check("idle", 16'(view_mode_o), 16'(MODE_A));
    brief(MODE_B);
    brief(MODE_C);
    watch(0, 550, 8'h04, "view");
    op.hold(RS + 100);
    brief(MODE_D);
    watch(0, 550, 8'h14, "view");
    port_up_i = ~port_up_i;
    repeat (3) @(negedge mclk_i);
    check("alarm", {15'h0, fault_lamp_o}, 16'h1);
    notes.push_back({6'h08, psu_ok_i, port_up_i});
    op.hold(AC + 100);
    brief(MODE_A);
    check("left", 16'(notes.size()), 16'h0);
    final_report();
  end
endmodule : button_led_mode_controller_tb
